/* File: core/smc_defs.vh */
// Purpose: Constants shared by the supply monitor control block.
// Assumes: 32-bit AHB-Lite data bus, registers one per aligned word.
// Notes: Bit positions follow the two control register and the status register byte layouts.
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// Register byte addresses.
`define SMC_ADDR_CTRL1 12'h000
`define SMC_ADDR_CTRL2 12'h004
`define SMC_ADDR_VEC 12'h008
`define SMC_ADDR_STAT 12'h00c
`define SMC_AW 12
// Control register 1 bit positions.
`define SMC_B1_FLAG 7
`define SMC_B1_ACK 6
`define SMC_B1_IRQ 5
`define SMC_B1_DRST 4
`define SMC_B1_DSTOP 3
`define SMC_B1_DON 2
`define SMC_B1_DRVH 1
`define SMC_B1_BGON 0
// Control register 2 bit positions.
`define SMC_B2_DTRIP 6
`define SMC_B2_WHI 5
`define SMC_B2_WLO 4
// Status register bit positions.
`define SMC_BS_C2W 2
`define SMC_BS_DET 1
`define SMC_BS_WARN 0
// Reset values.
`define SMC_RST_DON 1'b1
`define SMC_RST_DRST 1'b1
`define SMC_RST_DSTOP 1'b1
`define SMC_RST_WTRIP 2'h0
`define SMC_RST_DTRIP 1'b0
// Warning vector pair, high and low byte addresses.
`define SMC_VEC_WARN_HI 16'hfff8
`define SMC_VEC_WARN_LO 16'hfff9
// AHB encodings.
`define SMC_HTRANS_NONSEQ 2'h2
`define SMC_HSIZE_WORD 3'h2
`endif

/* File: core/smc_once.v */
// Purpose: A write-once control bit that accepts the first write after reset.
// Assumes: wr is a one-cycle write strobe on hclk.
// Notes: Later writes are dropped until the next reset.
`default_nettype none
module smc_once #(
  parameter RST_VAL = 1'b0
) (
  input wire hclk,
  input wire hresetn,
  input wire wr,
  input wire din,
  output wire dout
);
  reg val_q;
  reg done_q;

  // The lock flag closes the bit after its first write.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      val_q <= RST_VAL;
      done_q <= 1'b0;
    end else if (wr && !done_q) begin
      val_q <= din;
      done_q <= 1'b1;
    end
  end

  assign dout = val_q;
endmodule
`default_nettype wire

/* File: core/smc_sync.v */
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: Input may change at any time relative to hclk.
// Notes: Only the second stage may be read by other logic.
`default_nettype none
module smc_sync (
  input wire hclk,
  input wire hresetn,
  input wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;

  // The first stage feeds the second stage only, to contain metastability.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

/* File: core/smc_top.v */
// Purpose: Control and status logic of the supply-voltage monitor.
// Assumes: AHB-Lite slave, single word transfers, comparator inputs async.
// Notes: Analog trip levels live outside; this block selects and flags them.
// Notes: Write data take effect one edge after the address phase.
// Notes: Write-once bits lock on the first write to their register.
// Notes: The acknowledge clears the flag only once the warning is gone.
// Notes: The status word shows the synchronised levels and an init mark.
// Notes: The reset request stays up until the chip reset clears it.
// Notes on behaviour
// - Drive bit picks low or high buffer drive.
// - Control bit 0 switches bandgap buffer.
// - Detect trip select is write-once, low/high.
// - Two-bit warning field picks four levels.
// - Register 2 bits 7, 3..0 read zero.
// - Warning interrupt uses its own vector pair.
// - Detect enable accepts only first write.
// - Acknowledge clears flag only when supply recovered.
// - Interrupt requested while flag and enable set.
// - Detect reset enable, with detect enable set, lets a detect force chip reset.
`include "smc_defs.vh"
`default_nettype none
module smc_top (
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave port.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Comparator levels from the analog side, asynchronous to hclk.
  input wire warn_below,
  input wire detect_below,
  // Controls towards the analog side.
  output wire bandgap_buf_on,
  output wire bandgap_drive_high,
  output wire detect_logic_on,
  output wire detect_stop_on,
  output wire detect_trip_select,
  output wire [1:0] warning_trip_select,
  output wire warning_irq,
  // Fixed vector pair of the warning and the chip reset request.
  output wire [15:0] warning_vec_hi_addr,
  output wire [15:0] warning_vec_lo_addr,
  output wire chip_reset_req
);
  // Bus side state.
  reg wr_pend_q;
  reg [`SMC_AW-1:0] wr_addr_q;
  reg [31:0] rdata_q;
  // Control and status flops.
  reg bg_on_q;
  reg drv_hi_q;
  reg dstop_q;
  reg irq_on_q;
  reg [1:0] wtrip_q;
  reg flag_q;
  reg rst_req_q;
  reg ctrl2_wr_q;
  // Next values of the flops above.
  reg bg_on_d;
  reg drv_hi_d;
  reg dstop_d;
  reg irq_on_d;
  reg [1:0] wtrip_d;
  reg flag_d;
  reg rst_req_d;
  reg ctrl2_wr_d;
  // Synchronised levels, write-once outputs and decoded strobes.
  wire warn_s;
  wire detect_s;
  wire don;
  wire drst;
  wire dtrip;
  wire addr_ph;
  wire wr1;
  wire wr2;
  wire ack;

  // True when a pending write targets the given register. Both write
  // strobes use it, so the two decodes cannot drift apart.
  function wr_hit;
    input pend;
    input [`SMC_AW-1:0] wa;
    input [`SMC_AW-1:0] ra;
    begin
      wr_hit = pend && (wa == ra);
    end
  endfunction

  // Returns the byte value of a register, with unused bits as zero.
  // Unmapped addresses fall to the default and read as zero.
  function [7:0] reg_byte;
    input [`SMC_AW-1:0] a;
    begin
      reg_byte = 8'h00;
      case (a)
        `SMC_ADDR_CTRL1: begin
          // Bit 6 is the acknowledge strobe and always reads zero.
          reg_byte[`SMC_B1_FLAG] = flag_q;
          reg_byte[`SMC_B1_IRQ] = irq_on_q;
          reg_byte[`SMC_B1_DRST] = drst;
          reg_byte[`SMC_B1_DSTOP] = dstop_q;
          reg_byte[`SMC_B1_DON] = don;
          reg_byte[`SMC_B1_DRVH] = drv_hi_q;
          reg_byte[`SMC_B1_BGON] = bg_on_q;
        end
        `SMC_ADDR_CTRL2: begin
          // Bit 7 and bits 3..0 have no storage and stay zero.
          reg_byte[`SMC_B2_DTRIP] = dtrip;
          reg_byte[`SMC_B2_WHI:`SMC_B2_WLO] = wtrip_q;
        end
        `SMC_ADDR_STAT: begin
          // Bit 2 marks that software has written register 2 since reset.
          reg_byte[`SMC_BS_C2W] = ctrl2_wr_q;
          reg_byte[`SMC_BS_DET] = detect_s;
          reg_byte[`SMC_BS_WARN] = warn_s;
        end
        default: reg_byte = 8'h00;
      endcase
    end
  endfunction

  // Comparator levels cross into hclk through two flops each; nothing
  // reads the first stage, which may still be settling.
  smc_sync u_sync_warn (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(warn_below),
    .sync_out(warn_s)
  );
  // The detect level goes through its own pair of flops.
  smc_sync u_sync_det (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(detect_below),
    .sync_out(detect_s)
  );

  // Address phase decode; the slave never stalls, so hreadyout is high.
  // The transfer size is not checked: every register is one aligned word.
  assign addr_ph = hsel && hready && (htrans == `SMC_HTRANS_NONSEQ);

  // Data phase strobes; hwdata is valid only one cycle after the address.
  assign wr1 = wr_hit(wr_pend_q, wr_addr_q, `SMC_ADDR_CTRL1);
  assign wr2 = wr_hit(wr_pend_q, wr_addr_q, `SMC_ADDR_CTRL2);
  // The acknowledge bit is a strobe only; it is never stored or read back.
  assign ack = wr1 && hwdata[`SMC_B1_ACK];

  // Write address is held for the data phase that follows. Read data
  // stand unchanged until the next read address phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`SMC_AW{1'b0}};
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= haddr[`SMC_AW-1:0];
      if (addr_ph && !hwrite) begin
        if (haddr[`SMC_AW-1:0] == `SMC_ADDR_VEC) begin
          rdata_q <= {`SMC_VEC_WARN_HI, `SMC_VEC_WARN_LO};
        end else begin
          rdata_q <= {24'h000000, reg_byte(haddr[`SMC_AW-1:0])};
        end
      end
    end
  end

  // Write-once detect enable, detect reset enable and detect trip select.
  // Both register 1 bits lock together on the first register 1 write.
  smc_once #(.RST_VAL(`SMC_RST_DON)) u_once_don (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr1),
    .din(hwdata[`SMC_B1_DON]),
    .dout(don)
  );
  smc_once #(.RST_VAL(`SMC_RST_DRST)) u_once_drst (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr1),
    .din(hwdata[`SMC_B1_DRST]),
    .dout(drst)
  );
  smc_once #(.RST_VAL(`SMC_RST_DTRIP)) u_once_dtrip (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr2),
    .din(hwdata[`SMC_B2_DTRIP]),
    .dout(dtrip)
  );

  // Next values of the plain read/write controls. Reserved bits of
  // register 2 have no storage, so writes to them cannot stick.
  always @* begin
    bg_on_d = bg_on_q;
    drv_hi_d = drv_hi_q;
    dstop_d = dstop_q;
    irq_on_d = irq_on_q;
    wtrip_d = wtrip_q;
    ctrl2_wr_d = ctrl2_wr_q;
    if (wr1) begin
      bg_on_d = hwdata[`SMC_B1_BGON];
      drv_hi_d = hwdata[`SMC_B1_DRVH];
      dstop_d = hwdata[`SMC_B1_DSTOP];
      irq_on_d = hwdata[`SMC_B1_IRQ];
    end
    if (wr2) begin
      wtrip_d = hwdata[`SMC_B2_WHI:`SMC_B2_WLO];
      ctrl2_wr_d = 1'b1;
    end
  end

  // Control flops; they take their next values on every edge, so no
  // separate enable path can disagree with the decode above.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bg_on_q <= 1'b0;
      drv_hi_q <= 1'b0;
      dstop_q <= `SMC_RST_DSTOP;
      irq_on_q <= 1'b0;
      wtrip_q <= `SMC_RST_WTRIP;
      ctrl2_wr_q <= 1'b0;
    end else begin
      bg_on_q <= bg_on_d;
      drv_hi_q <= drv_hi_d;
      dstop_q <= dstop_d;
      irq_on_q <= irq_on_d;
      wtrip_q <= wtrip_d;
      ctrl2_wr_q <= ctrl2_wr_d;
    end
  end

  // Warning flag: a set from the comparator wins over an acknowledge, so a
  // warning that is still present cannot be lost by an early acknowledge.
  always @* begin
    flag_d = flag_q;
    if (warn_s) begin
      flag_d = 1'b1;
    end else if (ack) begin
      flag_d = 1'b0;
    end
  end

  // The flag flop; it comes out of reset clear and waits for a warning.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Reset request is sticky; the chip reset tree clears it with hresetn.
  // Only the synchronised detect level is used, to keep glitches out.
  always @* begin
    rst_req_d = rst_req_q;
    if (don && drst && detect_s) begin
      rst_req_d = 1'b1;
    end
  end

  // The request flop; nothing but hresetn ever lowers it.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= rst_req_d;
    end
  end

  // Bus outputs: no wait states and never an error response.
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Drive select is meaningful only while the buffer is on; a stale drive
  // bit must not reach the analog side while the buffer is off.
  assign bandgap_buf_on = bg_on_q;
  assign bandgap_drive_high = bg_on_q & drv_hi_q;

  // The stop enable only counts while the detect logic itself is on.
  assign detect_logic_on = don;
  assign detect_stop_on = don & dstop_q;
  assign detect_trip_select = dtrip;
  assign warning_trip_select = wtrip_q;

  // Polling software leaves the enable low and reads the flag instead.
  assign warning_irq = irq_on_q & flag_q;
  // The vector pair is fixed; the core fetches the handler from it.
  assign warning_vec_hi_addr = `SMC_VEC_WARN_HI;
  assign warning_vec_lo_addr = `SMC_VEC_WARN_LO;
  // The request goes to the chip reset tree as a plain level.
  assign chip_reset_req = rst_req_q;
endmodule
`default_nettype wire

/* File: testbench/smc_monitor.sv */
// Purpose: Port checks for the supply monitor control block.
// Assumes: One clock; write effects show two edges after the address phase.
// Notes: Write-once outputs may move once per reset.
`default_nettype none
module smc_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic detect_below,
  input wire logic bandgap_buf_on,
  input wire logic bandgap_drive_high,
  input wire logic detect_logic_on,
  input wire logic detect_trip_select,
  input wire logic [1:0] warning_trip_select,
  input wire logic warning_irq,
  input wire logic [15:0] warning_vec_hi_addr,
  input wire logic [15:0] warning_vec_lo_addr,
  input wire logic chip_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_phase;
  logic trip_moved_q;
  logic det_moved_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A write address phase; outputs may only move two edges later.
  assign wr_phase = hsel && htrans == 2'h2 && hwrite;
  // Remember the first move, since any later move is a fault.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_moved_q <= 1'b0;
      det_moved_q <= 1'b0;
    end else begin
      trip_moved_q <= trip_moved_q | $changed(detect_trip_select);
      det_moved_q <= det_moved_q | $changed(detect_logic_on);
    end
  end
  a_drive_gated: assert property (bandgap_drive_high |-> bandgap_buf_on)
    else $error("drive high without buffer");
  a_buf_by_write: assert property ($changed(bandgap_buf_on) |-> $past(wr_phase, 2))
    else $error("buffer moved without write");
  a_trip_once: assert property (trip_moved_q |-> $stable(detect_trip_select))
    else $error("detect trip moved twice");
  a_warn_by_write: assert property ($changed(warning_trip_select) |-> $past(wr_phase, 2))
    else $error("warning trip moved without write");
  a_vec_pair: assert property ({warning_vec_hi_addr, warning_vec_lo_addr} == 32'hfff8fff9)
    else $error("warning vector wrong");
  a_detect_once: assert property (det_moved_q |-> $stable(detect_logic_on))
    else $error("detect enable moved twice");
  a_reset_cause: assert property ($rose(chip_reset_req) |-> detect_logic_on && $past(detect_below, 3))
    else $error("reset request without detect");
  a_reset_sticky: assert property (chip_reset_req |=> chip_reset_req)
    else $error("reset request dropped");
  c_irq: cover property ($rose(warning_irq));
  c_rst: cover property ($rose(chip_reset_req));
  c_trip: cover property ($changed(warning_trip_select));
endmodule
bind smc_top smc_monitor mon_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .detect_below,
  .bandgap_buf_on, .bandgap_drive_high, .detect_logic_on, .detect_trip_select,
  .warning_trip_select, .warning_irq, .warning_vec_hi_addr, .warning_vec_lo_addr, .chip_reset_req);
`default_nettype wire

/* File: testbench/smc_tb_top.sv */
// Purpose: Self-checking bench for the supply monitor control block.
// Assumes: One AHB-Lite slave; comparators driven as plain levels.
// Notes: Only byte 0 of each register except the vector word is live; upper bits read zero.
`include "smc_defs.vh"
`default_nettype none
module smc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic warn_below = 1'b0;
  logic detect_below = 1'b0;
  wire [31:0] hrdata;
  wire [15:0] vec_hi, vec_lo;
  wire [1:0] warning_trip_select;
  wire hreadyout, bandgap_buf_on, bandgap_drive_high, detect_logic_on;
  wire detect_trip_select, warning_irq, chip_reset_req, hresp, detect_stop_on;
  int err_count = 0;
  int n_checks = 0;
  smc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .warn_below, .detect_below,
    .bandgap_buf_on, .bandgap_drive_high, .detect_logic_on, .detect_stop_on,
    .detect_trip_select, .warning_trip_select, .warning_irq, .warning_vec_hi_addr(vec_hi),
    .warning_vec_lo_addr(vec_lo), .chip_reset_req);
  // Free-running bus clock.
  always #2 hclk = ~hclk;
  task end_sim;
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single transfer; each phase is held until ready is seen high.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, r);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // Let the register outputs settle past the update edge.
  task settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Hang guard; the tests need about 100 cycles.
  initial begin
    repeat (4000) @(posedge hclk);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SMC_ADDR_CTRL2, 32'h0);
    rd(`SMC_ADDR_CTRL1, 32'h1c);
    wr(`SMC_ADDR_CTRL2, 8'hff);
    rd(`SMC_ADDR_CTRL2, 32'h70);
    rd(`SMC_ADDR_STAT, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(`SMC_ADDR_CTRL2, 8'(i << 4));
      settle(1);
      chk({29'h0, detect_trip_select, warning_trip_select}, 32'(4 + i));
    end
    wr(`SMC_ADDR_CTRL1, 8'h1f);
    settle(1);
    chk({30'h0, bandgap_buf_on, bandgap_drive_high}, 32'h3);
    chk(detect_stop_on, 32'h1);
    wr(`SMC_ADDR_CTRL1, 8'h01);
    rd(`SMC_ADDR_CTRL1, 32'h15);
    chk(detect_stop_on, 32'h0);
    wr(`SMC_ADDR_CTRL1, 8'h02);
    settle(1);
    chk({30'h0, bandgap_buf_on, bandgap_drive_high}, 32'h0);
    @(posedge hclk);
    warn_below <= 1'b1;
    settle(5);
    rd(`SMC_ADDR_CTRL1, 32'h96);
    wr(`SMC_ADDR_CTRL1, 8'h02);
    settle(1);
    chk(warning_irq, 32'h0);
    wr(`SMC_ADDR_CTRL1, 8'h62);
    settle(1);
    chk(warning_irq, 32'h1);
    @(posedge hclk);
    warn_below <= 1'b0;
    settle(4);
    wr(`SMC_ADDR_CTRL1, 8'h62);
    settle(1);
    chk(warning_irq, 32'h0);
    rd(`SMC_ADDR_CTRL1, 32'h36);
    rd(`SMC_ADDR_VEC, 32'hfff8fff9);
    chk({vec_hi, vec_lo}, 32'hfff8fff9);
    chk(hresp, 32'h0);
    wr(12'h010, 8'hff);
    rd(12'h010, 32'h0);
    detect_below <= 1'b1;
    settle(5);
    chk(chip_reset_req, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
